// >>> verilog/pist_pkg.sv
// Functional notes
// - Summary bit 15 shows power-state group pending
// - Summary bit 12 shows on-button group pending
// - Summary bit 7 shows power-path group pending
// - Summary bit 6 shows current-sink group pending
// - Summary bit 5 shows real-time-clock group pending
// - Summary bit 4 shows config-memory group pending
// - Summary bit 2 shows charger group pending
// - Summary bit 1 shows high-current group pending
// - Bits 14,13,11,8,0 carry remaining group summaries
// - Flags sticky; write one clears, zero keeps
// - Status one bits 15..13 set on rise
// - On-button and thermal change flags: both edges
// - Watchdog, data-ready, tick, alarm set on rise
// - Comparator flags follow programmed trigger direction
// - Battery hot/cold/fail/overvoltage/end set on rise
// - Charge timeout, mode, start set on rise
// - Current-sink flags set on rise
// - Command done/fail flags set on rise
// - Power-on-reset flag set on rise
// - Sleep-or-off entry flag set on rise
// - On-state entry flag set on rise
// - All mask bits reset to one, masked
package pist_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 16;

    // Register indices; the byte address is four times the index
    localparam logic [15:0] IDX_SUMMARY = 16'h4010;
    localparam logic [15:0] IDX_STATUS_ONE = 16'h4011;
    localparam logic [15:0] IDX_STATUS_TWO = 16'h4012;
    localparam logic [15:0] IDX_STATUS_THREE = 16'h4013;
    localparam logic [15:0] IDX_SYS_MASK = 16'h4018;
    localparam logic [15:0] IDX_MASK_ONE = 16'h4019;
    localparam logic [15:0] IDX_MASK_TWO = 16'h401a;
    localparam logic [15:0] IDX_MASK_THREE = 16'h401b;
    localparam logic [15:0] IDX_CMP_DIR = 16'h4020;

    localparam logic [31:0] ADDR_SUMMARY = {14'h0000, IDX_SUMMARY, 2'b00};
    localparam logic [31:0] ADDR_STATUS_ONE = {14'h0000, IDX_STATUS_ONE, 2'b00};
    localparam logic [31:0] ADDR_STATUS_TWO = {14'h0000, IDX_STATUS_TWO, 2'b00};
    localparam logic [31:0] ADDR_STATUS_THREE =
        {14'h0000, IDX_STATUS_THREE, 2'b00};
    localparam logic [31:0] ADDR_SYS_MASK = {14'h0000, IDX_SYS_MASK, 2'b00};
    localparam logic [31:0] ADDR_MASK_ONE = {14'h0000, IDX_MASK_ONE, 2'b00};
    localparam logic [31:0] ADDR_MASK_TWO = {14'h0000, IDX_MASK_TWO, 2'b00};
    localparam logic [31:0] ADDR_MASK_THREE =
        {14'h0000, IDX_MASK_THREE, 2'b00};
    localparam logic [31:0] ADDR_CMP_DIR = {14'h0000, IDX_CMP_DIR, 2'b00};

    // Summary bit positions
    localparam int unsigned SUM_POWER_STATE = 15;
    localparam int unsigned SUM_THERMAL = 14;
    localparam int unsigned SUM_GENERAL_PIN = 13;
    localparam int unsigned SUM_ON_BUTTON = 12;
    localparam int unsigned SUM_WATCHDOG = 11;
    localparam int unsigned SUM_AUX_CONVERTER = 8;
    localparam int unsigned SUM_POWER_PATH = 7;
    localparam int unsigned SUM_SINK = 6;
    localparam int unsigned SUM_RTC = 5;
    localparam int unsigned SUM_CONFIG_MEM = 4;
    localparam int unsigned SUM_CHARGER = 2;
    localparam int unsigned SUM_HIGH_CURRENT = 1;
    localparam int unsigned SUM_UNDERVOLTAGE = 0;

    // Group membership of status one flags
    localparam logic [15:0] GRP_POWER_PATH = 16'he000;
    localparam logic [15:0] GRP_ON_BUTTON = 16'h1000;
    localparam logic [15:0] GRP_WATCHDOG = 16'h0800;
    localparam logic [15:0] GRP_AUX_CONVERTER = 16'h01f0;
    localparam logic [15:0] GRP_RTC = 16'h000c;
    localparam logic [15:0] GRP_THERMAL = 16'h0002;
    // Group membership of status two flags
    localparam logic [15:0] GRP_CHARGER = 16'hff00;
    localparam logic [15:0] GRP_SINK = 16'h00c0;
    localparam logic [15:0] GRP_CONFIG_MEM = 16'h0030;
    localparam logic [15:0] GRP_POWER_STATE = 16'h0007;
    // Group membership of status three flags
    localparam logic [15:0] GRP_UNDERVOLTAGE = 16'h03ff;

    // Trigger kinds in status one
    localparam logic [15:0] ONE_RISE = 16'he90c;
    localparam logic [15:0] ONE_BOTH = 16'h1002;
    localparam int unsigned CMP_LSB = 4;
    localparam int unsigned CMP_NUM = 4;
    // Implemented flags; other bits read zero
    localparam logic [15:0] TWO_USED = 16'hfff7;
    localparam logic [15:0] THREE_USED = 16'h03ff;
    localparam int unsigned THREE_W = 10;

    // Values after reset
    localparam logic [15:0] FLAG_RST = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'hffff;
    localparam logic [3:0] CMP_DIR_RST = 4'hf;

endpackage : pist_pkg

// >>> verilog/pist_interrupt_status.sv
module pist_interrupt_status #(
    parameter int unsigned ADDR_W = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Raw event levels from the detectors, asynchronous
    input wire logic [15:0] event_one_raw,
    input wire logic [15:0] event_two_raw,
    input wire logic [9:0] event_three_raw,
    // Pending levels of groups kept elsewhere, same clock
    input wire logic general_pin_pending,
    input wire logic high_current_pending,
    // Masked interrupt request
    output logic irq
);

    typedef struct packed {
        logic [2:0][15:0] sync1;
        logic [2:0][15:0] sync2;
        logic [2:0][15:0] prev;
        logic [2:0][15:0] flag;
        logic [2:0][15:0] ev_mask;
        logic [15:0] sys_mask;
        logic [3:0] cmp_dir;
        logic [15:0] summary;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } pist_state_t;

    pist_state_t s_r;
    pist_state_t s_nxt;

    function automatic logic [15:0] pist_group_or(
        input logic [15:0] one,
        input logic [15:0] two,
        input logic [15:0] three,
        input logic gp,
        input logic hc
    );
        logic [15:0] g;
        g = 16'h0000;
        g[pist_pkg::SUM_POWER_STATE] =
            |(two & pist_pkg::GRP_POWER_STATE);
        g[pist_pkg::SUM_ON_BUTTON] = |(one & pist_pkg::GRP_ON_BUTTON);
        g[pist_pkg::SUM_POWER_PATH] = |(one & pist_pkg::GRP_POWER_PATH);
        g[pist_pkg::SUM_SINK] = |(two & pist_pkg::GRP_SINK);
        g[pist_pkg::SUM_RTC] = |(one & pist_pkg::GRP_RTC);
        g[pist_pkg::SUM_CONFIG_MEM] = |(two & pist_pkg::GRP_CONFIG_MEM);
        g[pist_pkg::SUM_CHARGER] = |(two & pist_pkg::GRP_CHARGER);
        g[pist_pkg::SUM_HIGH_CURRENT] = hc;
        g[pist_pkg::SUM_THERMAL] = |(one & pist_pkg::GRP_THERMAL);
        g[pist_pkg::SUM_GENERAL_PIN] = gp;
        g[pist_pkg::SUM_WATCHDOG] = |(one & pist_pkg::GRP_WATCHDOG);
        g[pist_pkg::SUM_AUX_CONVERTER] =
            |(one & pist_pkg::GRP_AUX_CONVERTER);
        g[pist_pkg::SUM_UNDERVOLTAGE] =
            |(three & pist_pkg::GRP_UNDERVOLTAGE);
        return g;
    endfunction : pist_group_or

    logic [2:0][15:0] rise;
    logic [2:0][15:0] fall;
    logic [2:0][15:0] set;
    logic [2:0][15:0] clr;
    logic [2:0][15:0] live;
    logic [15:0] lane;
    logic [15:0] wbits;
    logic [15:0] rd;
    logic [31:0] addr;
    logic setup;
    logic wr;
    logic hit;

    always_comb begin
        s_nxt = s_r;
        rise = '0;
        fall = '0;
        set = '0;
        clr = '0;
        live = '0;
        rd = 16'h0000;
        hit = 1'b0;
        addr = 32'(paddr);
        lane = {{8{pstrb[1]}}, {8{pstrb[0]}}};
        wbits = pwdata[15:0] & lane;
        setup = psel && !penable;
        // The access edge is the one where pready was already high
        wr = psel && penable && pwrite && s_r.pready;

        // Two stages before any logic sees a detector level
        s_nxt.sync1[0] = event_one_raw;
        s_nxt.sync1[1] = event_two_raw;
        s_nxt.sync1[2] = {{(16 - pist_pkg::THREE_W){1'b0}}, event_three_raw};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev = s_r.sync2;
        for (int k = 0; k < 3; k++) begin
            rise[k] = s_r.sync2[k] & ~s_r.prev[k];
            fall[k] = ~s_r.sync2[k] & s_r.prev[k];
        end

        set[0] = rise[0] & pist_pkg::ONE_RISE;
        set[0] = set[0] | ((rise[0] | fall[0]) & pist_pkg::ONE_BOTH);
        for (int i = 0; i < pist_pkg::CMP_NUM; i++) begin
            // Direction one: level went above threshold; zero: below
            set[0][pist_pkg::CMP_LSB + i] = s_r.cmp_dir[i]
                ? rise[0][pist_pkg::CMP_LSB + i]
                : fall[0][pist_pkg::CMP_LSB + i];
        end
        set[1] = rise[1] & pist_pkg::TWO_USED;
        set[2] = rise[2] & pist_pkg::THREE_USED;

        if (wr) begin
            if (addr == pist_pkg::ADDR_STATUS_ONE) begin
                clr[0] = wbits;
            end else if (addr == pist_pkg::ADDR_STATUS_TWO) begin
                clr[1] = wbits;
            end else if (addr == pist_pkg::ADDR_STATUS_THREE) begin
                clr[2] = wbits;
            end else if (addr == pist_pkg::ADDR_SYS_MASK) begin
                s_nxt.sys_mask = (s_r.sys_mask & ~lane) | wbits;
            end else if (addr == pist_pkg::ADDR_MASK_ONE) begin
                s_nxt.ev_mask[0] = (s_r.ev_mask[0] & ~lane) | wbits;
            end else if (addr == pist_pkg::ADDR_MASK_TWO) begin
                s_nxt.ev_mask[1] = (s_r.ev_mask[1] & ~lane) | wbits;
            end else if (addr == pist_pkg::ADDR_MASK_THREE) begin
                s_nxt.ev_mask[2] = (s_r.ev_mask[2] & ~lane) | wbits;
            end else if (addr == pist_pkg::ADDR_CMP_DIR && pstrb[0]) begin
                s_nxt.cmp_dir = pwdata[3:0];
            end
        end

        // A new event in the clearing cycle survives the clear
        for (int k = 0; k < 3; k++) begin
            s_nxt.flag[k] = (s_r.flag[k] & ~clr[k]) | set[k];
            live[k] = s_r.flag[k] & ~s_r.ev_mask[k];
        end

        s_nxt.summary = pist_group_or(s_r.flag[0], s_r.flag[1], s_r.flag[2],
            general_pin_pending, high_current_pending);
        s_nxt.irq = |(pist_group_or(live[0], live[1], live[2],
            general_pin_pending, high_current_pending)
            & ~s_r.sys_mask);

        // Answer is prepared in setup so the access needs no wait state
        if (addr[1:0] != 2'b00) begin
            hit = 1'b0;
        end else if (addr == pist_pkg::ADDR_SUMMARY) begin
            rd = s_r.summary;
            hit = 1'b1;
        end else if (addr == pist_pkg::ADDR_STATUS_ONE) begin
            rd = s_r.flag[0];
            hit = 1'b1;
        end else if (addr == pist_pkg::ADDR_STATUS_TWO) begin
            rd = s_r.flag[1];
            hit = 1'b1;
        end else if (addr == pist_pkg::ADDR_STATUS_THREE) begin
            rd = s_r.flag[2];
            hit = 1'b1;
        end else if (addr == pist_pkg::ADDR_SYS_MASK) begin
            rd = s_r.sys_mask;
            hit = 1'b1;
        end else if (addr == pist_pkg::ADDR_MASK_ONE) begin
            rd = s_r.ev_mask[0];
            hit = 1'b1;
        end else if (addr == pist_pkg::ADDR_MASK_TWO) begin
            rd = s_r.ev_mask[1];
            hit = 1'b1;
        end else if (addr == pist_pkg::ADDR_MASK_THREE) begin
            rd = s_r.ev_mask[2];
            hit = 1'b1;
        end else if (addr == pist_pkg::ADDR_CMP_DIR) begin
            rd = {12'h000, s_r.cmp_dir};
            hit = 1'b1;
        end
        s_nxt.pready = setup;
        s_nxt.pslverr = setup && !hit;
        s_nxt.prdata = (setup && !pwrite) ? {16'h0000, rd} : 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.sync1 <= '0;
            s_r.sync2 <= '0;
            s_r.prev <= '0;
            s_r.flag <= {3{pist_pkg::FLAG_RST}};
            s_r.ev_mask <= {3{pist_pkg::MASK_RST}};
            s_r.sys_mask <= pist_pkg::MASK_RST;
            s_r.cmp_dir <= pist_pkg::CMP_DIR_RST;
            s_r.summary <= 16'h0000;
            s_r.prdata <= 32'h0000_0000;
            s_r.pready <= 1'b0;
            s_r.pslverr <= 1'b0;
            s_r.irq <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq = s_r.irq;

endmodule : pist_interrupt_status

// >>> sim/pist_event_model.sv
module pist_event_model (
    // Clock
    input wire logic pclk,
    // Raw detector levels
    output logic [15:0] event_one_raw,
    output logic [15:0] event_two_raw,
    output logic [9:0] event_three_raw,
    output logic general_pin_pending,
    output logic high_current_pending
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {event_one_raw, event_two_raw, event_three_raw} = '0;
        {general_pin_pending, high_current_pending} = 2'b00;
    end

    // Levels stand six clocks so the two-stage synchroniser sees them
    task automatic drive(input logic [15:0] one, input logic [15:0] two,
                         input logic [9:0] three, input logic [1:0] pend);
        @(posedge pclk);
        event_one_raw <= one;
        event_two_raw <= two;
        event_three_raw <= three;
        {general_pin_pending, high_current_pending} <= pend;
        repeat (6) @(posedge pclk);
    endtask : drive
endmodule : pist_event_model

// >>> sim/pist_interrupt_status_props.sv
module pist_interrupt_status_props #(
    parameter int unsigned ADDR_W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] event_one_raw,
    input wire logic [15:0] event_two_raw,
    input wire logic [9:0] event_three_raw,
    input wire logic general_pin_pending,
    input wire logic high_current_pending,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Goes high once software has written anything, masks included
    logic any_wr_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            any_wr_r <= 1'b0;
        end else if (psel && penable && pready && pwrite) begin
            any_wr_r <= 1'b1;
        end
    end

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read(logic [31:0] a);
        s_setup ##0 (!pwrite && paddr == ADDR_W'(a));
    endsequence

    chk_ready_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    chk_err_unaligned: assert property
        (s_setup ##0 (paddr[1:0] != 2'b00) |=> pready && pslverr)
        else $error("unaligned access not refused");
    chk_idle_data: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside an answer");
    chk_sum_unused: assert property
        (s_read(pist_pkg::ADDR_SUMMARY) |=> prdata[31:16] == 16'h0
         && prdata[10:9] == 2'b00 && !prdata[3])
        else $error("summary unused bits not zero");
    chk_three_width: assert property
        (s_read(pist_pkg::ADDR_STATUS_THREE) |=> prdata[31:10] == 22'h0)
        else $error("status three above bit 9 not zero");
    chk_summary_ro: assert property
        (s_setup ##0 (pwrite && paddr == ADDR_W'(pist_pkg::ADDR_SUMMARY))
         |=> pready && !pslverr)
        else $error("summary write flagged as error");
    chk_mask_reset: assert property (!any_wr_r |-> !irq)
        else $error("irq with reset masks");
endmodule : pist_interrupt_status_props

bind pist_interrupt_status pist_interrupt_status_props #(
    .ADDR_W(ADDR_W)
) u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_one_raw(event_one_raw), .event_two_raw(event_two_raw),
    .event_three_raw(event_three_raw),
    .general_pin_pending(general_pin_pending),
    .high_current_pending(high_current_pending), .irq(irq));

// >>> sim/pist_interrupt_status_tb_top.sv
module pist_interrupt_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, rd_data;
    logic pready, pslverr, irq, rd_err;
    logic [15:0] ev_one, ev_two;
    logic [9:0] ev_three;
    logic gp_pend, hc_pend;
    int fail_count = 0;
    int checks_done = 0;

    always #5 pclk = ~pclk;

    pist_interrupt_status #(.ADDR_W(32)) DUT (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_one_raw(ev_one), .event_two_raw(ev_two),
        .event_three_raw(ev_three), .general_pin_pending(gp_pend),
        .high_current_pending(hc_pend), .irq(irq));
    pist_event_model src (.pclk(pclk), .event_one_raw(ev_one),
        .event_two_raw(ev_two), .event_three_raw(ev_three),
        .general_pin_pending(gp_pend), .high_current_pending(hc_pend));

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic compare(input string name, input logic [31:0] exp,
                           input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : compare

    // Entered just after a rising edge; ends one idle edge after the edge that completes
    task automatic apb(input logic [31:0] a, input logic wr,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        {paddr, pwrite, pwdata, pstrb} <= {a, wr, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            compare("pready wait", 32'h1, 32'h0);
            report_and_stop();
        end else begin
            rd_data = prdata;
            rd_err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // One idle edge, so a following call never reassigns psel
            @(posedge pclk);
        end
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        apb(a, 1'b1, {16'h0, d}, 4'h3);
    endtask : wr

    task automatic rdc(input string name, input logic [31:0] a,
                       input logic [31:0] exp);
        apb(a, 1'b0, 32'h0, 4'h0);
        compare(name, exp, rd_data);
    endtask : rdc

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            rdc("flags", pist_pkg::ADDR_SUMMARY + 32'(4 * i), 32'h0);
            rdc("mask", pist_pkg::ADDR_SYS_MASK + 32'(4 * i), 32'hffff);
        end
        rdc("direction", pist_pkg::ADDR_CMP_DIR, 32'hf);
        src.drive(16'hffff, 16'hffff, 10'h3ff, 2'b00);
        rdc("one", pist_pkg::ADDR_STATUS_ONE, 32'hf9fe);
        rdc("two", pist_pkg::ADDR_STATUS_TWO, 32'hfff7);
        rdc("three", pist_pkg::ADDR_STATUS_THREE, 32'h3ff);
        rdc("summary", pist_pkg::ADDR_SUMMARY, 32'hd9f5);
        // Only the low byte lane is written, so the charger byte survives
        apb(pist_pkg::ADDR_STATUS_TWO, 1'b1, 32'hffff, 4'h1);
        rdc("two", pist_pkg::ADDR_STATUS_TWO, 32'hff00);
        wr(pist_pkg::ADDR_STATUS_TWO, 16'hffff);
        wr(pist_pkg::ADDR_STATUS_THREE, 16'h03ff);
        wr(pist_pkg::ADDR_STATUS_ONE, 16'h0000);
        rdc("one", pist_pkg::ADDR_STATUS_ONE, 32'hf9fe);
        rdc("two", pist_pkg::ADDR_STATUS_TWO, 32'h0);
        rdc("summary", pist_pkg::ADDR_SUMMARY, 32'h59a0);
        wr(pist_pkg::ADDR_STATUS_ONE, 16'hffff);
        src.drive(16'h0000, 16'h0000, 10'h000, 2'b00);
        rdc("one", pist_pkg::ADDR_STATUS_ONE, 32'h1002);
        wr(pist_pkg::ADDR_CMP_DIR, 16'h0000);
        wr(pist_pkg::ADDR_STATUS_ONE, 16'hffff);
        src.drive(16'hffff, 16'h0000, 10'h000, 2'b11);
        rdc("one", pist_pkg::ADDR_STATUS_ONE, 32'hf90e);
        rdc("summary", pist_pkg::ADDR_SUMMARY, 32'h79a2);
        wr(pist_pkg::ADDR_STATUS_ONE, 16'hffff);
        src.drive(16'h0000, 16'h0000, 10'h000, 2'b00);
        rdc("one", pist_pkg::ADDR_STATUS_ONE, 32'h10f2);
        wr(pist_pkg::ADDR_MASK_THREE, 16'hfffe);
        wr(pist_pkg::ADDR_SYS_MASK, 16'hfffe);
        compare("irq", 32'h0, {31'h0, irq});
        src.drive(16'h0000, 16'h0000, 10'h001, 2'b00);
        compare("irq", 32'h1, {31'h0, irq});
        wr(pist_pkg::ADDR_STATUS_THREE, 16'h0001);
        repeat (3) @(posedge pclk);
        compare("irq", 32'h0, {31'h0, irq});
        apb(32'h0, 1'b0, 32'h0, 4'h0);
        compare("unmapped err", 32'h1, {31'h0, rd_err});
        compare("unmapped data", 32'h0, rd_data);
        apb(pist_pkg::ADDR_SUMMARY + 32'h1, 1'b0, 32'h0, 4'h0);
        compare("unaligned err", 32'h1, {31'h0, rd_err});
        apb(pist_pkg::ADDR_SUMMARY, 1'b1, 32'hffff, 4'h3);
        compare("summary write err", 32'h0, {31'h0, rd_err});
        report_and_stop();
    end
endmodule : pist_interrupt_status_tb_top
